// ---- design/tsrb_bank.sv ----
`timescale 1ns/10ps
`include "tsrb_params.svh"
// How it works
// - Pointer selects register, resets to 00h
// - Local result: high at 00h, nibble 15h
// - Remote result: high at 01h, nibble 10h
// - Low nibble is sixteenths of degree
// - Results read-only, refreshed per measurement
// - Reading one byte freezes its partner
// - Results clear to 00h on reset
// - Status at 02h with busy bit and seven flag bits
// - Alert mode ORs five flags, sets latch
// - Status read clears flags if cause gone
// - Latch released only by alert-response read
// - Overheat flags self-clear with hysteresis
// - Overheat pin low while either overheat flag is set
// - Second overheat mode uses high flags only
// - Mask bit zero enables alert output
// - Second overheat mode ignores mask
// - Write to 0Fh starts one-shot
// - Pin function bit selects alert or overheat
// - Shutdown bit stops after current conversion
// - Range bit selects extended span

module tsrb_bank #(
    parameter logic [7:0] MAKER_CODE = 8'hA7  // Arbitrary identity value
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Register access from the serial engine
    input  wire tsrb_pkg::tsrb_access_s acc,
    output      logic [7:0]            rdata,
    // Converter
    input  wire tsrb_pkg::tsrb_result_s result,
    output      logic                  conv_start,
    output      logic                  conv_busy,
    output      logic [3:0]            conv_rate,
    output      logic [1:0]            filter_sel,
    // Pins and option outputs
    output      logic                  alert_pin_n,
    output      logic                  overheat_pin_n,
    output      logic                  bus_level_option,
    output      logic                  bus_timeout_enable
);

    tsrb_pkg::tsrb_state_s st;
    tsrb_pkg::tsrb_state_s next_st;

    // ----------------------------------------
    // Derived conditions
    // ----------------------------------------
    logic        ext_range;
    logic [11:0] lt_disp;
    logic [11:0] rt_disp;
    logic [11:0] r_upper;
    logic [11:0] r_lower;
    logic        l_hi_cond;
    logic        l_lo_cond;
    logic        r_hi_cond;
    logic        r_lo_cond;
    logic        pin_second_oh;
    logic        any_flag;
    logic        wr_shot;
    logic        rd_status;
    logic [7:0]  status_byte;

    assign ext_range = st.cfg[`TSRB_CFG_RANGE];

    // Extended span shown with offset binary
    assign lt_disp = ext_range ? st.lt + `TSRB_RANGE_OFFSET : st.lt;
    assign rt_disp = ext_range ? st.rt + `TSRB_RANGE_OFFSET : st.rt;

    assign r_upper = {st.r_upper_hi, st.r_upper_lo[7:4]};
    assign r_lower = {st.r_lower_hi, st.r_lower_lo[7:4]};

    // Local limits compare high byte only; remote limits compare full 12-bit results
    assign l_hi_cond = lt_disp[11:4] > st.l_upper;
    assign l_lo_cond = lt_disp[11:4] < st.l_lower;
    assign r_hi_cond = rt_disp > r_upper;
    assign r_lo_cond = rt_disp < r_lower;

    assign pin_second_oh = st.cfg[`TSRB_CFG_PIN_FUNC];

    assign any_flag = |st.flags;

    assign wr_shot   = acc.data_wr && (st.ptr == `TSRB_WR_ONE_SHOT);
    assign rd_status = acc.data_rd && (st.ptr == `TSRB_RD_STATUS);

    assign status_byte = {st.conv == tsrb_pkg::TSRB_CONV,
                          st.flags.local_over_flag,
                          st.flags.local_under_flag,
                          st.flags.remote_over_flag,
                          st.flags.remote_under_flag,
                          st.flags.open_flag,
                          st.r_overheat,
                          st.l_overheat};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [7:0] rd;
        logic       l_oh_clear;
        logic       r_oh_clear;
        rd         = 8'h00;
        l_oh_clear = 1'b0;
        r_oh_clear = 1'b0;
        next_st    = st;

        if (acc.ptr_wr) begin
            next_st.ptr = acc.wdata;
        end

        case (st.ptr)
            `TSRB_RD_LT_HI:      rd = lt_disp[11:4];
            `TSRB_RD_RT_HI:      rd = rt_disp[11:4];
            `TSRB_RD_STATUS:     rd = status_byte;
            `TSRB_RD_CONFIG:     rd = st.cfg;
            `TSRB_RD_RATE:       rd = st.rate;
            `TSRB_RD_L_UPPER:    rd = st.l_upper;
            `TSRB_RD_L_LOWER:    rd = st.l_lower;
            `TSRB_RD_R_UPPER_HI: rd = st.r_upper_hi;
            `TSRB_RD_R_LOWER_HI: rd = st.r_lower_hi;
            `TSRB_RD_RT_LO:      rd = {rt_disp[3:0], 4'h0};
            `TSRB_RD_CORR_HI:    rd = st.corr_hi;
            `TSRB_RD_CORR_LO:    rd = st.corr_lo;
            `TSRB_RD_R_UPPER_LO: rd = st.r_upper_lo;
            `TSRB_RD_R_LOWER_LO: rd = st.r_lower_lo;
            `TSRB_RD_LT_LO:      rd = {lt_disp[3:0], 4'h0};
            `TSRB_RD_R_OVERHEAT: rd = st.r_ohlim;
            `TSRB_RD_L_OVERHEAT: rd = st.l_ohlim;
            `TSRB_RD_HYST:       rd = st.hyst;
            `TSRB_RD_ALERT_CFG:  rd = st.alcfg;
            `TSRB_RD_IDEALITY:   rd = st.ideal;
            `TSRB_RD_FILTER:     rd = st.filt;
            `TSRB_RD_MAKER:      rd = MAKER_CODE;
            // One-shot and unmapped read as zero
            default:             rd = 8'h00;
        endcase
        if (acc.data_rd) begin
            next_st.rdata = rd;
        end

        if (acc.data_wr) begin
            case (st.ptr)
                `TSRB_WR_CONFIG:     next_st.cfg = acc.wdata & `TSRB_CFG_MASK;
                `TSRB_WR_RATE:       next_st.rate = acc.wdata & `TSRB_RATE_MASK;
                `TSRB_WR_L_UPPER:    next_st.l_upper = acc.wdata;
                `TSRB_WR_L_LOWER:    next_st.l_lower = acc.wdata;
                `TSRB_WR_R_UPPER_HI: next_st.r_upper_hi = acc.wdata;
                `TSRB_WR_R_LOWER_HI: next_st.r_lower_hi = acc.wdata;
                `TSRB_RD_CORR_HI:    next_st.corr_hi = acc.wdata;
                `TSRB_RD_CORR_LO:    next_st.corr_lo = acc.wdata & `TSRB_NIB_MASK;
                `TSRB_RD_R_UPPER_LO: next_st.r_upper_lo = acc.wdata & `TSRB_NIB_MASK;
                `TSRB_RD_R_LOWER_LO: next_st.r_lower_lo = acc.wdata & `TSRB_NIB_MASK;
                `TSRB_RD_R_OVERHEAT: next_st.r_ohlim = acc.wdata;
                `TSRB_RD_L_OVERHEAT: next_st.l_ohlim = acc.wdata;
                `TSRB_RD_HYST:       next_st.hyst = acc.wdata;
                `TSRB_RD_ALERT_CFG: begin
                    next_st.alcfg = (acc.wdata & `TSRB_ALCFG_MASK) | `TSRB_ALCFG_ONE;
                end
                `TSRB_RD_IDEALITY:   next_st.ideal = acc.wdata;
                `TSRB_RD_FILTER:     next_st.filt = acc.wdata & `TSRB_FILT_MASK;
                default: begin
                end
            endcase
        end

        // Reading one byte freezes the partner
        if (acc.data_rd) begin
            case (st.ptr)
                `TSRB_RD_LT_HI: begin
                    next_st.lt_lock_lo = !st.lt_lock_hi;
                    next_st.lt_lock_hi = 1'b0;
                end
                `TSRB_RD_LT_LO: begin
                    next_st.lt_lock_hi = !st.lt_lock_lo;
                    next_st.lt_lock_lo = 1'b0;
                end
                `TSRB_RD_RT_HI: begin
                    next_st.rt_lock_lo = !st.rt_lock_hi;
                    next_st.rt_lock_hi = 1'b0;
                end
                `TSRB_RD_RT_LO: begin
                    next_st.rt_lock_hi = !st.rt_lock_lo;
                    next_st.rt_lock_lo = 1'b0;
                end
                default: begin
                end
            endcase
        end

        case (st.conv)
            tsrb_pkg::TSRB_IDLE: begin
                if (!st.cfg[`TSRB_CFG_SHUTDOWN]) begin
                    next_st.conv = tsrb_pkg::TSRB_CONV;
                end
            end
            tsrb_pkg::TSRB_CONV: begin
                if (result.valid) begin
                    next_st.conv = st.cfg[`TSRB_CFG_SHUTDOWN] ? tsrb_pkg::TSRB_STOP
                                                              : tsrb_pkg::TSRB_CONV;
                end
            end
            tsrb_pkg::TSRB_STOP: begin
                if (!st.cfg[`TSRB_CFG_SHUTDOWN]) begin
                    next_st.conv = tsrb_pkg::TSRB_CONV;
                end else if (wr_shot) begin
                    next_st.conv = tsrb_pkg::TSRB_CONV;
                end
            end
            default: next_st.conv = tsrb_pkg::TSRB_IDLE;
        endcase

        // Results refresh per measurement, locks respected
        if (result.valid && st.conv == tsrb_pkg::TSRB_CONV) begin
            // Only the frozen byte holds back
            if (!st.lt_lock_hi) begin
                next_st.lt[11:4] = result.local_temp[11:4];
            end
            if (!st.lt_lock_lo) begin
                next_st.lt[3:0] = result.local_temp[3:0];
            end
            if (!st.rt_lock_hi) begin
                next_st.rt[11:4] = result.remote_temp[11:4];
            end
            if (!st.rt_lock_lo) begin
                next_st.rt[3:0] = result.remote_temp[3:0];
            end
        end

        // Status read clears flags whose cause is gone
        if (rd_status) begin
            next_st.flags.local_over_flag   = l_hi_cond;
            next_st.flags.local_under_flag  = l_lo_cond;
            next_st.flags.remote_over_flag  = r_hi_cond && !result.remote_open;
            next_st.flags.remote_under_flag = r_lo_cond && !result.remote_open;
            next_st.flags.open_flag         = result.remote_open;
            next_st.flags = next_st.flags & st.flags;
        end
        // Set wins over clear
        next_st.flags.local_over_flag   = next_st.flags.local_over_flag | l_hi_cond;
        next_st.flags.local_under_flag  = next_st.flags.local_under_flag | l_lo_cond;
        next_st.flags.remote_over_flag  = next_st.flags.remote_over_flag | r_hi_cond;
        next_st.flags.remote_under_flag = next_st.flags.remote_under_flag | r_lo_cond;
        next_st.flags.open_flag         = next_st.flags.open_flag | result.remote_open;

        l_oh_clear = lt_disp[11:4] <= st.l_ohlim - st.hyst;
        r_oh_clear = rt_disp[11:4] <= st.r_ohlim - st.hyst;
        if (lt_disp[11:4] > st.l_ohlim) begin
            next_st.l_overheat = 1'b1;
        end else if (l_oh_clear) begin
            next_st.l_overheat = 1'b0;
        end
        if (rt_disp[11:4] > st.r_ohlim) begin
            next_st.r_overheat = 1'b1;
        end else if (r_oh_clear) begin
            next_st.r_overheat = 1'b0;
        end

        // Latch set by any flag in alert mode
        if (!pin_second_oh && any_flag) begin
            next_st.alert_latch = 1'b1;
        end else if (acc.ara_rd) begin
            next_st.alert_latch = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            st            <= '0;
            st.ptr        <= `TSRB_POR_PTR;
            st.conv       <= tsrb_pkg::TSRB_IDLE;
            st.lt         <= {`TSRB_POR_ZERO, 4'h0};
            st.rt         <= {`TSRB_POR_ZERO, 4'h0};
            st.rate       <= `TSRB_POR_RATE;
            st.l_upper    <= `TSRB_POR_L_UPPER;
            st.r_ohlim    <= `TSRB_POR_R_OVERHT;
            st.l_ohlim    <= `TSRB_POR_L_OVERHT;
            st.hyst       <= `TSRB_POR_HYST;
            st.alcfg      <= `TSRB_POR_ALERT_CFG;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata              = st.rdata;
    assign conv_busy          = st.conv == tsrb_pkg::TSRB_CONV;
    assign conv_start         = (st.conv != tsrb_pkg::TSRB_CONV) &&
                                (next_st.conv == tsrb_pkg::TSRB_CONV);
    assign conv_rate          = st.rate[3:0];
    assign filter_sel         = st.filt[1:0];
    assign bus_level_option   = st.cfg[`TSRB_CFG_BUS_LEVEL];
    assign bus_timeout_enable = st.alcfg[`TSRB_ALCFG_TIMEOUT];

    assign overheat_pin_n = !(st.l_overheat || st.r_overheat);

    // Mask gates alert; second overheat ignores mask and low flags
    assign alert_pin_n = pin_second_oh
        ? !(st.flags.local_over_flag || st.flags.remote_over_flag)
        : !(st.alert_latch && !st.cfg[`TSRB_CFG_ALERT_MSK]);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ptr_load: assert property (@(posedge clk) disable iff (reset)
        acc.ptr_wr |=> st.ptr == $past(acc.wdata))
        else $error("pointer not loaded");

    a_shot_start: assert property (@(posedge clk) disable iff (reset)
        (st.conv == tsrb_pkg::TSRB_STOP && st.cfg[`TSRB_CFG_SHUTDOWN] && wr_shot) |=> conv_busy)
        else $error("one-shot did not start");

    a_overheat_pin: assert property (@(posedge clk) disable iff (reset)
        st.l_overheat |-> !overheat_pin_n)
        else $error("overheat pin not low");

    a_mask_alert: assert property (@(posedge clk) disable iff (reset)
        (!pin_second_oh && st.cfg[`TSRB_CFG_ALERT_MSK]) |-> alert_pin_n)
        else $error("masked alert drove pin");

    a_latch_hold: assert property (@(posedge clk) disable iff (reset)
        (st.alert_latch && !acc.ara_rd) |=> st.alert_latch)
        else $error("alert latch released early");

    a_flag_set: assert property (@(posedge clk) disable iff (reset)
        l_hi_cond |=> st.flags.local_over_flag)
        else $error("high flag not set");

    sequence s_hi_read;
        acc.data_rd && st.ptr == `TSRB_RD_LT_HI && !st.lt_lock_hi;
    endsequence
    a_pair_lock: assert property (@(posedge clk) disable iff (reset)
        s_hi_read |=> st.lt_lock_lo)
        else $error("low byte not frozen");

    a_ro_result: assert property (@(posedge clk) disable iff (reset)
        !result.valid |=> st.lt == $past(st.lt))
        else $error("result changed without measurement");

    a_second_oh: assert property (@(posedge clk) disable iff (reset)
        (pin_second_oh && !st.flags.local_over_flag && !st.flags.remote_over_flag)
        |-> alert_pin_n)
        else $error("second overheat pin low without high flag");

    a_flag_clear: assert property (@(posedge clk) disable iff (reset)
        (rd_status && !l_hi_cond) |=> !st.flags.local_over_flag)
        else $error("stale high flag kept on status read");

    a_oh_release: assert property (@(posedge clk) disable iff (reset)
        (lt_disp[11:4] <= st.l_ohlim - st.hyst && lt_disp[11:4] <= st.l_ohlim)
        |=> !st.l_overheat)
        else $error("local overheat flag did not self-clear");

    a_latch_set: assert property (@(posedge clk) disable iff (reset)
        (!pin_second_oh && any_flag) |=> st.alert_latch)
        else $error("alert latch not set by flag");

    a_stop_after: assert property (@(posedge clk) disable iff (reset)
        (conv_busy && result.valid && st.cfg[`TSRB_CFG_SHUTDOWN]) |=> !conv_busy)
        else $error("conversion did not stop in shutdown");

    a_lock_hold: assert property (@(posedge clk) disable iff (reset)
        st.lt_lock_lo |=> st.lt[3:0] == $past(st.lt[3:0]))
        else $error("frozen low byte changed");

endmodule

// ---- design/tsrb_params.svh ----
`ifndef TSRB_PARAMS_SVH
`define TSRB_PARAMS_SVH

// ----------------------------------------
// Read pointers
// ----------------------------------------
`define TSRB_RD_LT_HI      8'h00
`define TSRB_RD_RT_HI      8'h01
`define TSRB_RD_STATUS     8'h02
`define TSRB_RD_CONFIG     8'h03
`define TSRB_RD_RATE       8'h04
`define TSRB_RD_L_UPPER    8'h05
`define TSRB_RD_L_LOWER    8'h06
`define TSRB_RD_R_UPPER_HI 8'h07
`define TSRB_RD_R_LOWER_HI 8'h08
`define TSRB_RD_RT_LO      8'h10
`define TSRB_RD_CORR_HI    8'h11
`define TSRB_RD_CORR_LO    8'h12
`define TSRB_RD_R_UPPER_LO 8'h13
`define TSRB_RD_R_LOWER_LO 8'h14
`define TSRB_RD_LT_LO      8'h15
`define TSRB_RD_R_OVERHEAT 8'h19
`define TSRB_RD_L_OVERHEAT 8'h20
`define TSRB_RD_HYST       8'h21
`define TSRB_RD_ALERT_CFG  8'h22
`define TSRB_RD_IDEALITY   8'h23
`define TSRB_RD_FILTER     8'h24
`define TSRB_RD_MAKER      8'hFE

// ----------------------------------------
// Write pointers (where they differ from read)
// ----------------------------------------
`define TSRB_WR_CONFIG     8'h09
`define TSRB_WR_RATE       8'h0A
`define TSRB_WR_L_UPPER    8'h0B
`define TSRB_WR_L_LOWER    8'h0C
`define TSRB_WR_R_UPPER_HI 8'h0D
`define TSRB_WR_R_LOWER_HI 8'h0E
`define TSRB_WR_ONE_SHOT   8'h0F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSRB_POR_PTR       8'h00
`define TSRB_POR_ZERO      8'h00
`define TSRB_POR_RATE      8'h08
`define TSRB_POR_L_UPPER   8'h55
`define TSRB_POR_R_OVERHT  8'h6C
`define TSRB_POR_L_OVERHT  8'h55
`define TSRB_POR_HYST      8'h0A
`define TSRB_POR_ALERT_CFG 8'h01

// ----------------------------------------
// Field masks and bit positions
// ----------------------------------------
`define TSRB_CFG_MASK      8'hE5
`define TSRB_RATE_MASK     8'h0F
`define TSRB_NIB_MASK      8'hF0
`define TSRB_ALCFG_MASK    8'h8E
`define TSRB_ALCFG_ONE     8'h01
`define TSRB_FILT_MASK     8'h03
`define TSRB_CFG_ALERT_MSK 7
`define TSRB_CFG_SHUTDOWN  6
`define TSRB_CFG_PIN_FUNC  5
`define TSRB_CFG_RANGE     2
`define TSRB_CFG_BUS_LEVEL 0
`define TSRB_ALCFG_TIMEOUT 7
`define TSRB_RANGE_OFFSET  12'h400

`endif

// ---- design/tsrb_pkg.sv ----
package tsrb_pkg;

    typedef enum logic [2:0] {
        TSRB_IDLE = 3'b001,
        TSRB_CONV = 3'b010,
        TSRB_STOP = 3'b100
    } tsrb_conv_e;

    // Five latched event flags
    typedef struct packed {
        logic local_over_flag;
        logic local_under_flag;
        logic remote_over_flag;
        logic remote_under_flag;
        logic open_flag;
    } tsrb_flags_s;

    // Converter result handed to the bank
    typedef struct packed {
        logic        valid;
        logic [11:0] local_temp;
        logic [11:0] remote_temp;
        logic        remote_open;
    } tsrb_result_s;

    // Register access port from the serial engine
    typedef struct packed {
        logic       ptr_wr;
        logic       data_wr;
        logic       data_rd;
        logic       ara_rd;
        logic [7:0] wdata;
    } tsrb_access_s;

    typedef struct packed {
        logic [7:0]  ptr;
        tsrb_conv_e  conv;
        logic [11:0] lt;
        logic [11:0] rt;
        logic        lt_lock_hi;
        logic        lt_lock_lo;
        logic        rt_lock_hi;
        logic        rt_lock_lo;
        tsrb_flags_s flags;
        logic        alert_latch;
        logic        l_overheat;
        logic        r_overheat;
        logic [7:0]  cfg;
        logic [7:0]  rate;
        logic [7:0]  l_upper;
        logic [7:0]  l_lower;
        logic [7:0]  r_upper_hi;
        logic [7:0]  r_lower_hi;
        logic [7:0]  r_upper_lo;
        logic [7:0]  r_lower_lo;
        logic [7:0]  corr_hi;
        logic [7:0]  corr_lo;
        logic [7:0]  r_ohlim;
        logic [7:0]  l_ohlim;
        logic [7:0]  hyst;
        logic [7:0]  alcfg;
        logic [7:0]  ideal;
        logic [7:0]  filt;
        logic [7:0]  rdata;
    } tsrb_state_s;

endpackage

// ---- test/tsrb_host.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Register-access host model
// ----------------------------------------
module tsrb_host (
    // Clock
    input  wire logic              clk,
    // Access port toward the bank
    output tsrb_pkg::tsrb_access_s acc
);
    initial acc = '0;

    // One strobe per access, released before the next one is raised
    task automatic op(input logic [3:0] k, input logic [7:0] d);
        @(posedge clk);
        acc <= {k, d};
        @(posedge clk);
        acc <= '0;
    endtask

    task automatic rd(input logic [7:0] a);
        op(4'h8, a);
        op(4'h2, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(4'h8, a);
        op(4'h4, d);
    endtask
endmodule

// ---- test/thermal_sensor_register_bank_tb.sv ----
`timescale 1ns/10ps
module thermal_sensor_register_bank_tb;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    tsrb_pkg::tsrb_access_s acc;
    tsrb_pkg::tsrb_result_s result = '0;
    logic [7:0]             rdata;
    logic                   conv_start;
    logic                   conv_busy;
    logic [3:0]             conv_rate;
    logic [1:0]             filter_sel;
    logic                   alert_pin_n;
    logic                   overheat_pin_n;
    logic                   bus_level_option;
    logic                   bus_timeout_enable;
    int                     fail_count = 0;
    int                     num_checks = 0;
    int                     seed = 61;
    logic [15:0]            exp_q[$];
    logic [15:0]            e;
    logic                   rd_d = 1'b0;
    logic [7:0]             start_count = 8'h00;
    localparam logic [7:0] RA [23] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h19, 8'h20, 8'h21,
        8'h22, 8'h23, 8'h24, 8'hFE, 8'h30};
    localparam logic [7:0] RV [23] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h55, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6C, 8'h55, 8'h0A,
        8'h01, 8'h00, 8'h00, 8'h3C, 8'h00};
    localparam logic [7:0] WA [8] = '{8'h0A, 8'h11, 8'h12, 8'h13, 8'h14, 8'h23, 8'h24, 8'h22};
    localparam logic [7:0] WB [8] = '{8'h04, 8'h11, 8'h12, 8'h13, 8'h14, 8'h23, 8'h24, 8'h22};
    localparam logic [7:0] WM [8] = '{8'h0F, 8'hFF, 8'hF0, 8'hF0, 8'hF0, 8'hFF, 8'h03, 8'h8E};

    always #4 clk = ~clk;

    tsrb_host host (.clk(clk), .acc(acc));

    // Maker code value is arbitrary
    tsrb_bank #(.MAKER_CODE(8'h3C)) uut (
        .clk(clk), .reset(reset), .acc(acc), .rdata(rdata), .result(result),
        .conv_start(conv_start), .conv_busy(conv_busy), .conv_rate(conv_rate),
        .filter_sel(filter_sel), .alert_pin_n(alert_pin_n),
        .overheat_pin_n(overheat_pin_n), .bus_level_option(bus_level_option),
        .bus_timeout_enable(bus_timeout_enable)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pin(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        exp_q.push_back({m, x});
        host.rd(a);
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (conv_busy !== lvl) begin
            @(posedge clk);
            n++;
            if (n > 3000) begin
                fail_count++;
                final_report();
            end
        end
    endtask

    task automatic measure(input logic [11:0] l, input logic [11:0] r, input logic o);
        @(posedge clk);
        wait_busy(1'b1);
        result <= {1'b1, l, r, o};
        @(posedge clk);
        // Open-diode condition is a level that holds until the next result
        result <= {1'b0, l, r, o};
        repeat (3) @(posedge clk);
    endtask

    // ----------------------------------------
    // Read monitor
    // ----------------------------------------
    always @(posedge clk) begin
        if (!reset && conv_start) begin
            start_count <= start_count + 8'h01;
        end
        if (rd_d) begin
            if (exp_q.size() == 0) begin
                check(rdata, 8'h00);
            end else begin
                e = exp_q.pop_front();
                check(rdata & e[15:8], e[7:0] & e[15:8]);
            end
        end
        rd_d <= acc.data_rd;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 23; i++) rd(RA[i], RV[i], 8'hFF);
        rd(8'h02, 8'h00, 8'h7F);
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            host.wr(WA[i], v);
            rd(WB[i], (v & WM[i]) | (i == 7 ? 8'h01 : 8'h00), 8'hFF);
            if (i == 0) check({4'h0, conv_rate}, v & 8'h0F);
            if (i == 6) check({6'h00, filter_sel}, v & 8'h03);
        end
        pin(bus_timeout_enable, v[7]);
        host.wr(8'h22, 8'h00);
        host.wr(8'h14, 8'h00);
        rd(8'h02, 8'h00, 8'h77);
        host.op(4'h1, 8'h00);
        host.wr(8'h01, 8'($random(seed)));
        rd(8'h01, 8'h00, 8'hFF);
        rd(8'h10, 8'h00, 8'hFF);
        host.wr(8'h09, 8'h01);
        rd(8'h03, 8'h01, 8'hFF);
        pin(bus_level_option, 1'b1);
        host.wr(8'h09, 8'h00);
        host.wr(8'h0D, 8'h7F);
        measure(12'h3A5, 12'h1F3, 1'b0);
        rd(8'h00, 8'h3A, 8'hFF);
        rd(8'h15, 8'h50, 8'hFF);
        rd(8'h01, 8'h1F, 8'hFF);
        rd(8'h10, 8'h30, 8'hFF);
        rd(8'h00, 8'h3A, 8'hFF);
        rd(8'h10, 8'h30, 8'hFF);
        measure(12'h123, 12'h2C7, 1'b0);
        rd(8'h15, 8'h50, 8'hFF);
        rd(8'h00, 8'h12, 8'hFF);
        rd(8'h01, 8'h1F, 8'hFF);
        rd(8'h10, 8'h70, 8'hFF);
        rd(8'h15, 8'h50, 8'hFF);
        rd(8'h01, 8'h1F, 8'hFF);
        measure(12'h600, 12'h200, 1'b1);
        pin(alert_pin_n, 1'b0);
        pin(overheat_pin_n, 1'b0);
        rd(8'h02, 8'h45, 8'h7F);
        measure(12'h300, 12'h200, 1'b0);
        pin(overheat_pin_n, 1'b1);
        rd(8'h02, 8'h44, 8'h7F);
        rd(8'h02, 8'h00, 8'h7F);
        pin(alert_pin_n, 1'b0);
        host.op(4'h1, 8'h00);
        repeat (2) @(posedge clk);
        pin(alert_pin_n, 1'b1);
        host.wr(8'h09, 8'h80);
        measure(12'h600, 12'h200, 1'b0);
        pin(alert_pin_n, 1'b1);
        host.wr(8'h09, 8'hA0);
        repeat (2) @(posedge clk);
        pin(alert_pin_n, 1'b0);
        measure(12'h300, 12'h200, 1'b0);
        rd(8'h02, 8'h40, 8'h7F);
        repeat (2) @(posedge clk);
        pin(alert_pin_n, 1'b1);
        host.wr(8'h09, 8'h04);
        measure(12'h300, 12'h200, 1'b0);
        rd(8'h00, 8'h70, 8'hFF);
        rd(8'h15, 8'h00, 8'hFF);
        host.wr(8'h09, 8'h40);
        measure(12'h300, 12'h200, 1'b0);
        repeat (4) @(posedge clk);
        pin(conv_busy, 1'b0);
        rd(8'h02, 8'h00, 8'h80);
        host.wr(8'h0F, 8'h5A);
        wait_busy(1'b1);
        pin(conv_busy, 1'b1);
        rd(8'h03, 8'h40, 8'hFF);
        rd(8'h0F, 8'h00, 8'hFF);
        measure(12'h300, 12'h200, 1'b0);
        pin(conv_busy, 1'b0);
        repeat (4) @(posedge clk);
        check(start_count, 8'h02);
        final_report();
    end
endmodule
